// ==== hw/fbch_pkg.sv ====
// Shared constants and types of the flash block command handler.
// Assumes a single 100 MHz clock domain and an AXI4-Lite register slave.

package fbch_pkg;

    // ========================================================
    // Storage geometry, buffer sizes and AXI bus widths
    // ========================================================
    localparam int unsigned NUM_BLOCKS_DEF = 119;
    localparam int unsigned BLOCK_BYTES_DEF = 512;
    localparam int unsigned BUF_BYTES_DEF = 256;
    localparam int unsigned AXI_ADDR_W = 8;
    localparam int unsigned AXI_DATA_W = 32;

    // ========================================================
    // Command and reply codes, erased byte value and zero field
    // ========================================================
    localparam logic [7:0] CMD_GEOMETRY = 8'h00;
    localparam logic [7:0] CMD_ERASE = 8'h01;
    localparam logic [7:0] CMD_WRITE = 8'h02;
    localparam logic [7:0] CMD_ERASE_WRITE = 8'h03;
    localparam logic [7:0] REPLY_FLAG = 8'h80;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [15:0] ZERO_FIELD = 16'h0000;

    // ========================================================
    // Register byte offsets
    // ========================================================
    localparam logic [7:0] OFS_REQ_WORD0 = 8'h00;
    localparam logic [7:0] OFS_REQ_WORD1 = 8'h04;
    localparam logic [7:0] OFS_CTRL = 8'h08;
    localparam logic [7:0] OFS_DATA_PUSH = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_RSP_WORD0 = 8'h14;
    localparam logic [7:0] OFS_RSP_WORD1 = 8'h18;
    localparam logic [7:0] OFS_RSP_DEST = 8'h1C;
    localparam logic [7:0] OFS_MEM_ADDR = 8'h20;
    localparam logic [7:0] OFS_MEM_DATA = 8'h24;

    // ========================================================
    // Field positions
    // ========================================================
    localparam int unsigned CTRL_UNICAST_BIT = 0;
    localparam int unsigned CTRL_EP_LSB = 8;
    localparam int unsigned CTRL_GO_BIT = 31;
    localparam int unsigned STAT_BUSY_BIT = 0;
    localparam int unsigned STAT_RSP_BIT = 1;
    localparam int unsigned STAT_REFUSED_BIT = 2;
    localparam int unsigned STAT_COUNT_LSB = 16;
    localparam int unsigned STATUS_ERR_BIT = 0;

    // ========================================================
    // Reset values and bus answers
    // ========================================================
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CHECK,
        ST_ERASE,
        ST_FETCH,
        ST_STORE,
        ST_REPLY
    } fbch_state_t;

endpackage : fbch_pkg

// ==== hw/fbch_mem.sv ====
// Single-port byte memory with registered read data.
// Assumes one writer and one reader share the port through an outside mux.

`timescale 1ns/1ps

module fbch_mem #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 256,
    parameter int unsigned ADDR_W = $clog2(DEPTH)
) (
    input wire logic clk,
    input wire logic we,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [WIDTH-1:0] wdata,
    output logic [WIDTH-1:0] rdata
);

    logic [WIDTH-1:0] cells [DEPTH];

    // No reset on the array: contents are undefined until written
    always_ff @(posedge clk) begin
        if (we) begin
            cells[addr] <= wdata;
        end
        rdata <= cells[addr];
    end

endmodule : fbch_mem

// ==== hw/fbch_top.sv ====
// Flash block command handler: takes a request payload over AXI4-Lite,
// runs geometry, erase, write or erase-then-write on a byte store and
// posts a reply payload. Assumes software loads the request then sets GO.
//
// Overview of operation
// - Geometry query reply carries code 0x80
// - Status bit 0 flags failure, rest reserved
// - Geometry reply block field holds block count
// - Geometry reply offset field holds block size
// - Geometry and erase replies: count zero, no data
// - Code 0x01 erases addressed block to ones
// - Erase with count zero erases whole store
// - Erase reply carries code 0x81
// - Erase reply echoes block and offset
// - Reply only to unicast, to source endpoint
// - Code 0x03 erases block then writes
// - Payload layout fixed, 16-bit fields big-endian
// - Broadcast commands get no reply
//
// The AXI4-Lite slave port and the register addresses were decided locally.

`timescale 1ns/1ps

module fbch_top #(
    parameter int unsigned NUM_BLOCKS = fbch_pkg::NUM_BLOCKS_DEF,
    parameter int unsigned BLOCK_BYTES = fbch_pkg::BLOCK_BYTES_DEF,
    parameter int unsigned BUF_BYTES = fbch_pkg::BUF_BYTES_DEF
) (
    input wire logic MCLK,
    input wire logic RESET_N,
    input wire logic [fbch_pkg::AXI_ADDR_W-1:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [fbch_pkg::AXI_DATA_W-1:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [fbch_pkg::AXI_ADDR_W-1:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [fbch_pkg::AXI_DATA_W-1:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    output logic RESPONSE_PENDING
);
    import fbch_pkg::*;

    localparam int unsigned STORE_BYTES = NUM_BLOCKS * BLOCK_BYTES;
    localparam int unsigned ST_AW = $clog2(STORE_BYTES);
    localparam int unsigned BUF_AW = $clog2(BUF_BYTES);
    localparam int unsigned CNT_W = $clog2(BUF_BYTES + 1);

    // ========================================================
    // Helpers
    // ========================================================
    function automatic logic [31:0] merge_strb(input logic [31:0] old_word,
                                               input logic [31:0] new_word,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old_word;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_word[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge_strb

    function automatic logic [ST_AW-1:0] store_addr(input logic [15:0] blk,
                                                    input logic [15:0] ofs);
        return ST_AW'(32'(blk) * BLOCK_BYTES + 32'(ofs));
    endfunction : store_addr

    function automatic logic [7:0] word_addr(input logic [7:0] a);
        return {a[7:2], 2'b00};
    endfunction : word_addr

    // ========================================================
    // Register state
    // ========================================================
    logic [31:0] req_word0;
    logic [31:0] req_word1;
    logic ctrl_unicast;
    logic [7:0] ctrl_ep;
    logic [CNT_W-1:0] buf_count;
    logic rsp_pending;
    logic go_refused;
    logic [31:0] rsp_word0;
    logic [31:0] rsp_word1;
    logic [7:0] rsp_dest;
    logic [ST_AW-1:0] mem_addr;

    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [7:0] ar_addr;
    logic rd_wait;

    fbch_state_t state;
    logic [7:0] job_cmd;
    logic [15:0] job_blk;
    logic [15:0] job_ofs;
    logic [15:0] job_cnt;
    logic job_unicast;
    logic [7:0] job_ep;
    logic job_err;
    logic job_write;
    logic [ST_AW-1:0] eng_addr;
    logic [ST_AW-1:0] erase_last;
    logic [ST_AW-1:0] wr_base;
    logic [15:0] wr_idx;

    logic wr_fire;
    logic go_req;
    logic push_req;
    logic w1c_rsp;
    logic w1c_refused;
    logic mapped_wr;
    logic idle;

    logic st_we;
    logic [ST_AW-1:0] st_addr;
    logic [7:0] st_wdata;
    logic [7:0] st_rdata;
    logic buf_we;
    logic [BUF_AW-1:0] buf_addr;
    logic [7:0] buf_rdata;
    logic [31:0] rd_mux;
    logic rd_ok;

    assign idle = (state == ST_IDLE);
    // Both halves held and no answer outstanding: the write is applied now
    assign wr_fire = !AWREADY && !WREADY && !BVALID;
    assign go_req = wr_fire && (word_addr(aw_addr) == OFS_CTRL)
                    && w_strb[3] && w_data[CTRL_GO_BIT];
    assign push_req = wr_fire && (word_addr(aw_addr) == OFS_DATA_PUSH) && w_strb[0]
                      && idle && (buf_count < CNT_W'(BUF_BYTES));
    assign w1c_rsp = wr_fire && (word_addr(aw_addr) == OFS_STATUS) && w_strb[0]
                     && w_data[STAT_RSP_BIT];
    assign w1c_refused = wr_fire && (word_addr(aw_addr) == OFS_STATUS) && w_strb[0]
                         && w_data[STAT_REFUSED_BIT];

    always_comb begin
        case (word_addr(aw_addr))
            OFS_REQ_WORD0, OFS_REQ_WORD1, OFS_CTRL, OFS_DATA_PUSH,
            OFS_STATUS, OFS_MEM_ADDR: mapped_wr = 1'b1;
            default: mapped_wr = 1'b0;
        endcase
    end

    // ========================================================
    // AXI4-Lite write channel
    // ========================================================
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            AWREADY <= 1'b1;
            WREADY <= 1'b1;
            BVALID <= 1'b0;
            BRESP <= RESP_OKAY;
            aw_addr <= 8'h00;
            w_data <= RESET_WORD;
            w_strb <= 4'h0;
        end else begin
            if (AWVALID && AWREADY) begin
                aw_addr <= AWADDR;
                AWREADY <= 1'b0;
            end
            if (WVALID && WREADY) begin
                w_data <= WDATA;
                w_strb <= WSTRB;
                WREADY <= 1'b0;
            end
            if (wr_fire) begin
                BVALID <= 1'b1;
                BRESP <= mapped_wr ? RESP_OKAY : RESP_SLVERR;
            end
            // Ready returns only after the answer, so one write at a time
            if (BVALID && BREADY) begin
                BVALID <= 1'b0;
                AWREADY <= 1'b1;
                WREADY <= 1'b1;
            end
        end
    end

    // Request payload bytes 0..7 held big-endian, byte 0 in the top lane
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            req_word0 <= RESET_WORD;
            req_word1 <= RESET_WORD;
            ctrl_unicast <= 1'b0;
            ctrl_ep <= 8'h00;
            mem_addr <= '0;
        end else if (wr_fire) begin
            case (word_addr(aw_addr))
                OFS_REQ_WORD0: req_word0 <= merge_strb(req_word0, w_data, w_strb);
                OFS_REQ_WORD1: req_word1 <= merge_strb(req_word1, w_data, w_strb);
                OFS_CTRL: begin
                    if (w_strb[0]) begin
                        ctrl_unicast <= w_data[CTRL_UNICAST_BIT];
                    end
                    if (w_strb[1]) begin
                        ctrl_ep <= w_data[CTRL_EP_LSB +: 8];
                    end
                end
                OFS_MEM_ADDR: mem_addr <= ST_AW'(merge_strb(32'(mem_addr), w_data, w_strb));
                default: ;
            endcase
        end
    end

    // Data bytes append from payload byte 8 onward; cleared when a job ends
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            buf_count <= '0;
        end else if (state == ST_REPLY) begin
            buf_count <= '0;
        end else if (push_req) begin
            buf_count <= buf_count + CNT_W'(1);
        end
    end

    // Set wins over a software clear in the same cycle
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rsp_pending <= 1'b0;
            go_refused <= 1'b0;
        end else begin
            if (state == ST_REPLY && job_unicast) begin
                rsp_pending <= 1'b1;
            end else if (w1c_rsp) begin
                rsp_pending <= 1'b0;
            end
            if (go_req && !idle) begin
                go_refused <= 1'b1;
            end else if (w1c_refused) begin
                go_refused <= 1'b0;
            end
        end
    end

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            RESPONSE_PENDING <= 1'b0;
        end else begin
            RESPONSE_PENDING <= (state == ST_REPLY && job_unicast)
                                || (rsp_pending && !w1c_rsp);
        end
    end

    // ========================================================
    // AXI4-Lite read channel
    // ========================================================
    always_comb begin
        rd_ok = 1'b1;
        case (word_addr(ar_addr))
            OFS_REQ_WORD0: rd_mux = req_word0;
            OFS_REQ_WORD1: rd_mux = req_word1;
            OFS_CTRL: rd_mux = {16'h0000, ctrl_ep, 7'h00, ctrl_unicast};
            OFS_DATA_PUSH: rd_mux = RESET_WORD;
            OFS_STATUS: rd_mux = {16'(buf_count), 13'h0000, go_refused, rsp_pending, !idle};
            OFS_RSP_WORD0: rd_mux = rsp_word0;
            OFS_RSP_WORD1: rd_mux = rsp_word1;
            OFS_RSP_DEST: rd_mux = {24'h000000, rsp_dest};
            OFS_MEM_ADDR: rd_mux = 32'(mem_addr);
            OFS_MEM_DATA: rd_mux = {24'h000000, st_rdata};
            default: begin
                rd_mux = RESET_WORD;
                rd_ok = 1'b0;
            end
        endcase
    end

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ARREADY <= 1'b1;
            RVALID <= 1'b0;
            RDATA <= RESET_WORD;
            RRESP <= RESP_OKAY;
            ar_addr <= 8'h00;
            rd_wait <= 1'b0;
        end else begin
            if (ARVALID && ARREADY) begin
                ar_addr <= ARADDR;
                ARREADY <= 1'b0;
                rd_wait <= 1'b1;
            end
            // One wait cycle lets the captured read address reach the read mux
            if (rd_wait) begin
                rd_wait <= 1'b0;
                RVALID <= 1'b1;
                RDATA <= rd_mux;
                RRESP <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end
            if (RVALID && RREADY) begin
                RVALID <= 1'b0;
                ARREADY <= 1'b1;
            end
        end
    end

    // ========================================================
    // Command engine
    // ========================================================
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state <= ST_IDLE;
            job_cmd <= 8'h00;
            job_blk <= ZERO_FIELD;
            job_ofs <= ZERO_FIELD;
            job_cnt <= ZERO_FIELD;
            job_unicast <= 1'b0;
            job_ep <= 8'h00;
            job_err <= 1'b0;
            job_write <= 1'b0;
            eng_addr <= '0;
            erase_last <= '0;
            wr_base <= '0;
            wr_idx <= ZERO_FIELD;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (go_req) begin
                        job_cmd <= req_word0[31:24];
                        job_blk <= req_word0[15:0];
                        job_ofs <= req_word1[31:16];
                        job_cnt <= req_word1[15:0];
                        job_unicast <= w_strb[0] ? w_data[CTRL_UNICAST_BIT] : ctrl_unicast;
                        job_ep <= w_strb[1] ? w_data[CTRL_EP_LSB +: 8] : ctrl_ep;
                        job_err <= 1'b0;
                        job_write <= 1'b0;
                        state <= ST_CHECK;
                    end
                end
                ST_CHECK: begin
                    wr_idx <= ZERO_FIELD;
                    wr_base <= store_addr(job_blk, job_ofs);
                    case (job_cmd)
                        CMD_GEOMETRY: state <= ST_REPLY;
                        CMD_ERASE: begin
                            if (job_cnt == ZERO_FIELD) begin
                                eng_addr <= '0;
                                erase_last <= ST_AW'(STORE_BYTES - 1);
                                state <= ST_ERASE;
                            end else if (32'(job_blk) < NUM_BLOCKS) begin
                                eng_addr <= store_addr(job_blk, ZERO_FIELD);
                                erase_last <= store_addr(job_blk, 16'(BLOCK_BYTES - 1));
                                state <= ST_ERASE;
                            end else begin
                                job_err <= 1'b1;
                                state <= ST_REPLY;
                            end
                        end
                        CMD_WRITE, CMD_ERASE_WRITE: begin
                            // Refuse before touching storage if the span is bad
                            if (32'(job_blk) >= NUM_BLOCKS
                                || 32'(job_ofs) + 32'(job_cnt) > BLOCK_BYTES
                                || 32'(job_cnt) > 32'(buf_count)) begin
                                job_err <= 1'b1;
                                state <= ST_REPLY;
                            end else if (job_cmd == CMD_ERASE_WRITE) begin
                                job_write <= 1'b1;
                                eng_addr <= store_addr(job_blk, ZERO_FIELD);
                                erase_last <= store_addr(job_blk, 16'(BLOCK_BYTES - 1));
                                state <= ST_ERASE;
                            end else if (job_cnt == ZERO_FIELD) begin
                                state <= ST_REPLY;
                            end else begin
                                state <= ST_FETCH;
                            end
                        end
                        default: begin
                            job_err <= 1'b1;
                            state <= ST_REPLY;
                        end
                    endcase
                end
                ST_ERASE: begin
                    eng_addr <= eng_addr + ST_AW'(1);
                    if (eng_addr == erase_last) begin
                        if (job_write && job_cnt != ZERO_FIELD) begin
                            state <= ST_FETCH;
                        end else begin
                            state <= ST_REPLY;
                        end
                    end
                end
                ST_FETCH: state <= ST_STORE;
                ST_STORE: begin
                    wr_idx <= wr_idx + 16'h0001;
                    if (wr_idx + 16'h0001 == job_cnt) begin
                        state <= ST_REPLY;
                    end else begin
                        state <= ST_FETCH;
                    end
                end
                ST_REPLY: state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Reply payload bytes 0..7, big-endian, written only for unicast jobs
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rsp_word0 <= RESET_WORD;
            rsp_word1 <= RESET_WORD;
            rsp_dest <= 8'h00;
        end else if (state == ST_REPLY && job_unicast) begin
            rsp_dest <= job_ep;
            rsp_word0[31:24] <= job_cmd | REPLY_FLAG;
            rsp_word0[23:16] <= {7'h00, job_err};
            rsp_word1[15:0] <= ZERO_FIELD;
            if (job_cmd == CMD_GEOMETRY) begin
                rsp_word0[15:0] <= 16'(NUM_BLOCKS);
                rsp_word1[31:16] <= 16'(BLOCK_BYTES);
            end else begin
                rsp_word0[15:0] <= job_blk;
                rsp_word1[31:16] <= job_ofs;
            end
        end
    end

    // ========================================================
    // Storage and data buffer ports
    // ========================================================
    always_comb begin
        st_we = 1'b0;
        st_wdata = ERASED_BYTE;
        st_addr = mem_addr;
        buf_we = push_req;
        buf_addr = BUF_AW'(buf_count);
        case (state)
            ST_ERASE: begin
                st_we = 1'b1;
                st_addr = eng_addr;
            end
            ST_FETCH: buf_addr = BUF_AW'(wr_idx);
            ST_STORE: begin
                st_we = 1'b1;
                st_addr = wr_base + ST_AW'(wr_idx);
                st_wdata = buf_rdata;
                buf_addr = BUF_AW'(wr_idx);
            end
            default: ;
        endcase
    end

    fbch_mem #(
        .WIDTH(8),
        .DEPTH(STORE_BYTES)
    ) u_store (
        .clk(MCLK),
        .we(st_we),
        .addr(st_addr),
        .wdata(st_wdata),
        .rdata(st_rdata)
    );

    fbch_mem #(
        .WIDTH(8),
        .DEPTH(BUF_BYTES)
    ) u_data_buf (
        .clk(MCLK),
        .we(buf_we),
        .addr(buf_addr),
        .wdata(w_data[7:0]),
        .rdata(buf_rdata)
    );

endmodule : fbch_top

// ==== testbench/fbch_monitor.sv ====
// Checker for the handler's top-level pins.
// Assumes it is bound to fbch_top.
`timescale 1ns/1ps
module fbch_monitor (
    input wire logic MCLK, RESET_N, AWVALID, AWREADY, WVALID, WREADY,
    input wire logic BVALID, BREADY, ARVALID, ARREADY, RVALID, RREADY,
    input wire logic [1:0] RRESP,
    input wire logic [31:0] RDATA,
    input wire logic RESPONSE_PENDING
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RESET_N);
    // ==========
    // Bus answers
    chk_wr_answer: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID)
        else $error("write answer missing");
    chk_b_hold: assert property (BVALID && !BREADY |=> BVALID)
        else $error("write answer dropped");
    chk_rd_answer: assert property (ARVALID && ARREADY |-> ##2 RVALID)
        else $error("read answer missing");
    chk_r_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("read answer changed");
    chk_ar_drop: assert property (ARVALID && ARREADY |=> !ARREADY)
        else $error("read address taken twice");
    chk_aw_drop: assert property (AWVALID && AWREADY |=> !AWREADY)
        else $error("write address taken twice");
    chk_rresp_code: assert property (RVALID |-> RRESP inside {2'h0, 2'h2})
        else $error("bad read response code");
    // Pending only clears through a register write
    chk_pend_clear: assert property ($fell(RESPONSE_PENDING) |-> BVALID)
        else $error("reply flag lost");
endmodule : fbch_monitor

// ==== testbench/fbch_host.sv ====
// AXI4-Lite master standing for the requesting node.
// Assumes the bench calls wr and rd one at a time.
`timescale 1ns/1ps
module fbch_host (
    input wire logic MCLK, AWREADY, WREADY, BVALID, ARREADY, RVALID,
    input wire logic [31:0] RDATA,
    output logic [7:0] AWADDR, ARADDR,
    output logic [31:0] WDATA,
    output logic [3:0] WSTRB,
    output logic AWVALID, WVALID, BREADY, ARVALID, RREADY
);
    initial {AWADDR, ARADDR, WDATA, WSTRB, AWVALID, WVALID, BREADY, ARVALID, RREADY} = '0;
    // Released lines show the inverse so stale values never pass as live
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge MCLK);
        {AWADDR, WDATA, WSTRB, AWVALID, WVALID, BREADY} <= {a, d, 4'hF, 3'h7};
        do begin
            @(posedge MCLK);
            if (AWREADY && AWVALID) {AWVALID, AWADDR} <= {1'b0, ~a};
            if (WREADY && WVALID) {WVALID, WDATA} <= {1'b0, ~d};
        end while (!BVALID);
        BREADY <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge MCLK);
        {ARADDR, ARVALID, RREADY} <= {a, 2'h3};
        do begin
            @(posedge MCLK);
            if (ARREADY && ARVALID) {ARVALID, ARADDR} <= {1'b0, ~a};
        end while (!RVALID);
        d = RDATA;
        RREADY <= 1'b0;
    endtask : rd
endmodule : fbch_host

// ==== testbench/flash_block_command_handler_tb_top.sv ====
// Bench: jobs go through the host model, register reads are scored.
// Assumes a store of 4 blocks of 16 bytes so erase-all stays short.
`timescale 1ns/1ps
module flash_block_command_handler_tb_top;
    import fbch_pkg::*;
    logic MCLK = 1'b0, RESET_N = 1'b0;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, RESPONSE_PENDING;
    logic AWVALID, WVALID, BREADY, ARVALID, RREADY;
    logic [7:0] AWADDR, ARADDR;
    logic [31:0] WDATA, RDATA, v, seed = 32'h96905345;
    logic [3:0] WSTRB;
    logic [1:0] BRESP, RRESP;
    logic [33:0] notes [$];
    logic [7:0] b [4];
    int num_errors = 0, n_compared = 0;
    always #5 MCLK = ~MCLK;
    fbch_top #(.NUM_BLOCKS(4), .BLOCK_BYTES(16), .BUF_BYTES(16)) dut (.MCLK, .RESET_N,
        .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID,
        .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY,
        .RESPONSE_PENDING);
    fbch_host h (.MCLK, .AWREADY, .WREADY, .BVALID, .ARREADY, .RVALID, .RDATA, .AWADDR,
        .ARADDR, .WDATA, .WSTRB, .AWVALID, .WVALID, .BREADY, .ARVALID, .RREADY);
    task automatic cmp(input string n, input logic [33:0] e, g);
        n_compared++;
        if (e !== g) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : cmp
    always @(posedge MCLK) if (RVALID && RREADY && notes.size() > 0)
        cmp("rdata", notes.pop_front(), {RRESP, RDATA});
    always @(posedge MCLK) if (BVALID && BREADY)
        cmp("bresp", {32'h0, RESP_OKAY}, {32'h0, BRESP});
    // Note goes in off the edge so a poll read finishing now is not paired
    task automatic chk(input logic [7:0] a, input logic [33:0] e);
        @(negedge MCLK);
        notes.push_back(e);
        h.rd(a, v);
    endtask : chk
    task automatic job(input logic [31:0] w0, w1, c);
        h.wr(OFS_REQ_WORD0, w0);
        h.wr(OFS_REQ_WORD1, w1);
        h.wr(OFS_CTRL, c);
        do h.rd(OFS_STATUS, v); while (v[STAT_BUSY_BIT] !== 1'b0);
    endtask : job
    task automatic mem(input logic [7:0] a, e);
        h.wr(OFS_MEM_ADDR, {24'h0, a});
        chk(OFS_MEM_DATA, {26'h0, e});
    endtask : mem
    task automatic push(input int n);
        for (int i = 0; i < n; i++) begin
            seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
            b[i] = seed[7:0];
            h.wr(OFS_DATA_PUSH, {24'h0, b[i]});
        end
    endtask : push
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : finish_test
    initial begin
        #400000;
        num_errors++;
        finish_test();
    end
    initial begin
        repeat (8) @(posedge MCLK);
        RESET_N <= 1'b1;
        job(32'h0, 32'h0, 32'h8000_0501);
        chk(OFS_RSP_WORD0, 34'h0_8000_0004);
        chk(OFS_RSP_WORD1, 34'h0_0010_0000);
        chk(OFS_RSP_DEST, 34'h5);
        cmp("pending", 34'h1, 34'(RESPONSE_PENDING));
        h.wr(OFS_STATUS, 32'h2);
        $display("geometry done");
        job(32'h0100_0002, 32'h0, 32'h8000_0101);
        chk(OFS_RSP_WORD0, 34'h0_8100_0002);
        for (int i = 0; i < 64; i += 21) mem(8'(i), 8'hFF);
        $display("erase done");
        push(4);
        job(32'h0200_0001, 32'h0004_0004, 32'h8000_0101);
        chk(OFS_RSP_WORD1, 34'h0_0004_0000);
        for (int i = 0; i < 4; i++) mem(8'(20 + i), b[i]);
        $display("write done");
        push(2);
        job(32'h0301_0001, 32'h0000_0002, 32'h8000_0101);
        chk(OFS_RSP_WORD0, 34'h0_8300_0001);
        for (int i = 0; i < 2; i++) mem(8'(16 + i), b[i]);
        mem(8'h14, 8'hFF);
        $display("erase-write done");
        job(32'h0100_0001, 32'h0000_0010, 32'h8000_0101);
        chk(OFS_RSP_WORD1, 34'h0);
        mem(8'h10, 8'hFF);
        $display("block erase done");
        job(32'h0200_0004, 32'h0000_0001, 32'h8000_0101);
        chk(OFS_RSP_WORD0, 34'h0_8201_0004);
        push(2);
        job(32'h0200_0000, 32'h000F_0002, 32'h8000_0101);
        chk(OFS_RSP_WORD0, 34'h0_8201_0000);
        mem(8'h0F, 8'hFF);
        h.wr(OFS_STATUS, 32'h2);
        job(32'h0, 32'h0, 32'h8000_0100);
        cmp("pending", 34'h0, 34'(RESPONSE_PENDING));
        chk(OFS_RSP_WORD0, 34'h0_8201_0000);
        chk(8'h40, {RESP_SLVERR, 32'h0});
        $display("faults done");
        finish_test();
    end
endmodule : flash_block_command_handler_tb_top
bind fbch_top fbch_monitor u_mon (.MCLK, .RESET_N, .AWVALID, .AWREADY, .WVALID, .WREADY,
    .BVALID, .BREADY, .ARVALID, .ARREADY, .RVALID, .RREADY, .RRESP, .RDATA,
    .RESPONSE_PENDING);
